// >>> common/hfp_pkg.sv
// package: offsets, field layouts and carriers of the host fifo port block
package hfp_pkg;

	// ==========================================================
	// bus geometry
	localparam int DW = 32;             // host data width
	localparam int ADW = 8;             // host byte address width

	// ==========================================================
	// byte offsets of the host window
	localparam logic [7:0] OFS_RXD_BASE  = 8'h00; // rx data, aliased 00..1c
	localparam logic [7:0] OFS_TXD_BASE  = 8'h20; // tx data, aliased 20..3c
	localparam logic [7:0] OFS_RXS_POP   = 8'h40; // rx status, destructive
	localparam logic [7:0] OFS_RXS_PEEK  = 8'h44; // rx status, look only
	localparam logic [7:0] OFS_TXS_POP   = 8'h48; // tx status, destructive
	localparam logic [7:0] OFS_TXS_PEEK  = 8'h4c; // tx status, look only
	localparam logic [7:0] OFS_IDENT     = 8'h50; // read-only identity
	localparam logic [7:0] OFS_FIFO_CFG  = 8'h54; // fifo capacity limits
	localparam logic [7:0] OFS_EVENT     = 8'h58; // sticky event bits
	localparam logic [7:0] OFS_ACTION    = 8'h5c; // self-clearing actions
	localparam int ALIAS_MSB = 7;                 // alias window = addr[7:5]
	localparam int ALIAS_LSB = 5;
	localparam int HALF_SEL  = 1;                 // half select in 16-bit mode

	// ==========================================================
	// reset values and field layout
	localparam logic [31:0] IDENT_VALUE   = 32'h00c3_0001; // arbitrary value
	localparam logic [31:0] FIFO_CFG_RST  = 32'h0000_0000;
	localparam logic [31:0] CFG_KEEP_MASK = 32'hff00_0000; // survives soft rst
	localparam int CFG_FW      = 8;       // width of each limit field
	localparam int CFG_RXD_LSB = 0;       // rx data capacity limit
	localparam int CFG_TXD_LSB = 8;       // tx data capacity limit
	localparam int CFG_RXS_LSB = 16;      // rx status capacity limit
	localparam int EV_RX_OVR   = 0;       // rx data pushed while full
	localparam int EV_TX_OVR   = 1;       // tx data pushed while full
	localparam int EV_RX_UDR   = 2;       // rx pop while empty
	localparam int EV_LINK_LL  = 3;       // link dropped since last read
	localparam int EV_ALERT_LH = 4;       // alert seen since last read
	localparam int EV_NUM      = 5;
	localparam int ACT_SOFT_RST = 0;      // software reset request
	localparam int ACT_RX_FLUSH = 1;      // flush both rx queues
	localparam int ACT_NUM      = 2;

	// ==========================================================
	// access attribute of a status bit
	typedef enum logic [3:0] {
		ATTR_W1C = 4'b0001,           // write_one_clear_attr
		ATTR_COR = 4'b0010,           // clear_on_read_attr
		ATTR_LL  = 4'b0100,           // latching_low_attr
		ATTR_LH  = 4'b1000            // latching_high_attr
	} hfp_attr_e;

	// host request carrier, synchronous to clock
	typedef struct packed {
		logic            rd;          // read strobe, one cycle
		logic            wr;          // write strobe, one cycle
		logic [ADW-1:0]  addr;        // byte address offset
		logic [DW-1:0]   wdata;       // write data
	} hfp_host_req_s;

endpackage

// >>> design/hfp_fifo.sv
// file: flip-flop queue with a capacity limit for the host fifo port
`timescale 1ns/1ps
module hfp_fifo
	import hfp_pkg::*;
#(
	parameter int W     = 32,          // entry width
	parameter int DEPTH = 16           // entries, power of two, at most 128
) (
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic          flush,
	input  wire logic [7:0]    limit,
	input  wire logic          push,
	input  wire logic [W-1:0]  push_data,
	input  wire logic          pop,
	output logic      [W-1:0]  head,
	output logic      [7:0]    count,
	output logic               full,
	output logic               empty
);
	localparam int PW = $clog2(DEPTH);

	// ==========================================================
	// storage and pointers
	logic [W-1:0]  mem [DEPTH];         // entries, no reset needed
	logic [PW-1:0] wptr_q;              // next slot to fill
	logic [PW-1:0] rptr_q;              // oldest entry
	logic [7:0]    cnt_q;               // entries held
	logic [7:0]    lim_w;               // effective capacity
	logic          do_push;
	logic          do_pop;

	// zero or oversized limit means the whole depth
	assign lim_w   = (limit == 8'h00 || limit > 8'(DEPTH)) ? 8'(DEPTH)
	               : limit;
	assign full    = cnt_q >= lim_w;
	assign empty   = cnt_q == 8'h00;
	assign do_push = push & ~full;      // a full queue keeps its entries
	assign do_pop  = pop & ~empty;      // empty pop leaves pointers
	assign head    = mem[rptr_q];
	assign count   = cnt_q;

	// entry write, data only
	always_ff @(posedge clock) begin
		if (do_push) begin
			mem[wptr_q] <= push_data;
		end
	end

	// pointer and count update
	always_ff @(posedge clock) begin
		if (!rst_n || flush) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q  <= 8'h00;
		end else begin
			wptr_q <= do_push ? wptr_q + 1'b1 : wptr_q;
			rptr_q <= do_pop ? rptr_q + 1'b1 : rptr_q;
			cnt_q  <= cnt_q + 8'(do_push) - 8'(do_pop);
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_FULL_KEEPS: assert property (
		push && full && !pop && !flush |=> cnt_q == $past(cnt_q))
		else $error("push into full queue changed its count");
	AST_EMPTY_POP: assert property (
		pop && empty && !flush |=> rptr_q == $past(rptr_q))
		else $error("pop of empty queue moved the read pointer");

endmodule // hfp_fifo

// >>> design/hfp_attr_bit.sv
// file: one status bit with a selectable host access attribute
`timescale 1ns/1ps
module hfp_attr_bit
	import hfp_pkg::*;
#(
	parameter hfp_attr_e KIND = ATTR_W1C  // access attribute of this bit
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic soft_rst,
	input  wire logic cond,
	input  wire logic rd_clr,
	input  wire logic wr_one,
	output logic      q
);
	// ==========================================================
	// next state per attribute
	logic bit_q;
	logic bit_d;
	logic rst_val;                      // latch-low idles high

	assign rst_val = (KIND == ATTR_LL);
	// the setting condition always wins over a clear in the same cycle
	assign bit_d =
		(KIND == ATTR_W1C) ? (cond | (bit_q & ~wr_one)) :
		(KIND == ATTR_COR) ? (cond | (bit_q & ~rd_clr)) :
		(KIND == ATTR_LH)  ? (rd_clr ? cond : (bit_q | cond)) :
		                     (rd_clr ? cond : (bit_q & cond));
	assign q = bit_q;

	// all reset types restore the default
	always_ff @(posedge clock) begin
		if (!rst_n || soft_rst) begin
			bit_q <= rst_val;
		end else begin
			bit_q <= bit_d;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n || soft_rst);

	if (KIND == ATTR_W1C) begin : g_w1c
		AST_W1C_CLEARS: assert property (
			wr_one && !cond |=> !bit_q)
			else $error("write one did not clear the bit");
		AST_W0_KEEPS: assert property (
			bit_q && !wr_one |=> bit_q)
			else $error("write zero disturbed the bit");
	end
	if (KIND == ATTR_COR) begin : g_cor
		AST_COR_CLEARS: assert property (
			rd_clr && !cond |=> !bit_q)
			else $error("read did not clear the bit");
	end
	if (KIND == ATTR_LH) begin : g_lh
		AST_LH_HOLDS: assert property (
			bit_q && !rd_clr |=> bit_q)
			else $error("latched high bit dropped before a read");
	end

endmodule // hfp_attr_bit

// >>> design/hfp_host_port.sv
// file: host register window with the four host fifo ports
`timescale 1ns/1ps
// Summary of operation
// - writes to read-only locations change nothing
// - write-only locations always read as zero
// - writing one clears the bit, zero keeps
// - clear-on-read bits clear when read
// - latching bits hold until read, then clear
// - immune fields survive software reset
// - reserved bits read as zero
// - reserved locations read as zero
// - every reset loads register defaults, except the immune field on software reset
// - four queues, three with programmable capacity
// - rx status pop returns and removes oldest
// - rx status peek returns oldest, no removal
// - rx data read consumes the word, in 16-bit mode only on the upper half
// - eight rx data aliases pop alike
// - tx data is write-only, write pushes, in 16-bit mode only on the upper half
// - eight tx data aliases push alike
// - tx status pop returns and removes oldest
// - tx status peek leaves queue untouched
// - registers sit at base plus fixed offset
module hfp_host_port
	import hfp_pkg::*;
#(
	parameter int RXD_DEPTH = 16,      // rx data entries
	parameter int TXD_DEPTH = 16,      // tx data entries
	parameter int RXS_DEPTH = 8,       // rx status entries
	parameter int TXS_DEPTH = 8        // tx status entries
) (
	input  wire logic           clock,
	input  wire logic           rst_n,
	input  wire hfp_host_req_s  host_req,
	input  wire logic           host_bus16,
	output logic      [DW-1:0]  host_rdata,
	output logic                host_rvalid,
	input  wire logic           rxd_push,
	input  wire logic [DW-1:0]  rxd_push_data,
	input  wire logic           rxs_push,
	input  wire logic [DW-1:0]  rxs_push_data,
	input  wire logic           txs_push,
	input  wire logic [DW-1:0]  txs_push_data,
	input  wire logic           txd_take,
	output logic                txd_valid,
	output logic      [DW-1:0]  txd_data,
	input  wire logic           link_ok,
	input  wire logic           alert_in
);
	localparam hfp_attr_e EV_ATTR [EV_NUM] =
		'{ATTR_W1C, ATTR_W1C, ATTR_COR, ATTR_LL, ATTR_LH};

	// ==========================================================
	// address decode
	logic [5:0]  word_a;               // word index of the access
	logic        rd;                   // read strobe
	logic        wr;                   // write strobe
	logic        sel_rxd;              // any of the rx data aliases
	logic        sel_txd;              // any of the tx data aliases
	logic        sel_rxs_pop;
	logic        sel_rxs_peek;
	logic        sel_txs_pop;
	logic        sel_txs_peek;
	logic        sel_ident;
	logic        sel_cfg;
	logic        sel_event;
	logic        sel_action;
	logic        upper_half;           // second half word in 16-bit mode

	assign rd     = host_req.rd;
	assign wr     = host_req.wr;   // no write path to read-only places
	assign word_a = host_req.addr[7:2];
	// every alias of a window decodes alike: low bits are ignored
	assign sel_rxd      = host_req.addr[ALIAS_MSB:ALIAS_LSB] ==
	                      OFS_RXD_BASE[ALIAS_MSB:ALIAS_LSB];
	assign sel_txd      = host_req.addr[ALIAS_MSB:ALIAS_LSB] ==
	                      OFS_TXD_BASE[ALIAS_MSB:ALIAS_LSB];
	assign sel_rxs_pop  = word_a == OFS_RXS_POP[7:2];
	assign sel_rxs_peek = word_a == OFS_RXS_PEEK[7:2];
	assign sel_txs_pop  = word_a == OFS_TXS_POP[7:2];
	assign sel_txs_peek = word_a == OFS_TXS_PEEK[7:2];
	assign sel_ident    = word_a == OFS_IDENT[7:2];
	assign sel_cfg      = word_a == OFS_FIFO_CFG[7:2];
	assign sel_event    = word_a == OFS_EVENT[7:2];
	assign sel_action   = word_a == OFS_ACTION[7:2];
	assign upper_half   = host_req.addr[HALF_SEL];

	// ==========================================================
	// control registers
	logic [DW-1:0]      cfg_q;         // capacity limits and keep field
	logic [DW-1:0]      cfg_d;
	logic [ACT_NUM-1:0] act_q;         // pending self-clearing actions
	logic [ACT_NUM-1:0] act_d;
	logic               soft_rst;      // software reset in progress
	logic               rx_flush;      // rx queues flush this cycle
	logic               all_flush;

	assign soft_rst  = act_q[ACT_SOFT_RST];
	assign rx_flush  = act_q[ACT_RX_FLUSH] | soft_rst;
	assign all_flush = soft_rst;

	// soft reset keeps the immune field and reloads the rest
	assign cfg_d =
		soft_rst ? ((cfg_q & CFG_KEEP_MASK) |
		            (FIFO_CFG_RST & ~CFG_KEEP_MASK)) :
		(wr && sel_cfg) ? host_req.wdata : cfg_q;
	// an action stays pending exactly one cycle, the cycle it acts
	assign act_d = (wr && sel_action) ? host_req.wdata[ACT_NUM-1:0]
	             : {ACT_NUM{1'b0}};

	// configuration and action registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cfg_q <= FIFO_CFG_RST;
			act_q <= {ACT_NUM{1'b0}};
		end else begin
			cfg_q <= cfg_d;
			act_q <= act_d;
		end
	end

	// ==========================================================
	// the four queues
	logic [DW-1:0] rxd_head;
	logic [DW-1:0] rxs_head;
	logic [DW-1:0] txs_head;
	logic [DW-1:0] txd_head;
	logic [7:0]    rxd_cnt;
	logic [7:0]    rxs_cnt;
	logic [7:0]    txs_cnt;
	logic [7:0]    txd_cnt;
	logic          rxd_full;
	logic          txd_full;
	logic          rxd_empty;
	logic          rxs_empty;
	logic          txs_empty;
	logic          txd_empty;
	logic          rxd_pop;
	logic          rxs_pop;
	logic          txs_pop;
	logic          txd_pop;
	logic          txd_push;
	logic [DW-1:0] txd_push_data;
	logic [15:0]   tx_lo_q;            // low half waiting in 16-bit mode

	// in 16-bit mode the word moves with its upper half
	assign rxd_pop  = rd & sel_rxd & (~host_bus16 | upper_half);
	assign rxs_pop  = rd & sel_rxs_pop;
	assign txs_pop  = rd & sel_txs_pop;
	assign txd_push = wr & sel_txd & (~host_bus16 | upper_half);
	assign txd_push_data = host_bus16 ?
		{host_req.wdata[15:0], tx_lo_q} : host_req.wdata;

	// capacities of three queues come from the config register
	hfp_fifo #(.W(DW), .DEPTH(RXD_DEPTH)) u_rxd (
		.clock     (clock),
		.rst_n     (rst_n),
		.flush     (rx_flush),
		.limit     (cfg_q[CFG_RXD_LSB +: CFG_FW]),
		.push      (rxd_push),
		.push_data (rxd_push_data),
		.pop       (rxd_pop),
		.head      (rxd_head),
		.count     (rxd_cnt),
		.full      (rxd_full),
		.empty     (rxd_empty)
	);
	hfp_fifo #(.W(DW), .DEPTH(RXS_DEPTH)) u_rxs (
		.clock     (clock),
		.rst_n     (rst_n),
		.flush     (rx_flush),
		.limit     (cfg_q[CFG_RXS_LSB +: CFG_FW]),
		.push      (rxs_push),
		.push_data (rxs_push_data),
		.pop       (rxs_pop),
		.head      (rxs_head),
		.count     (rxs_cnt),
		.full      (),
		.empty     (rxs_empty)
	);
	hfp_fifo #(.W(DW), .DEPTH(TXD_DEPTH)) u_txd (
		.clock     (clock),
		.rst_n     (rst_n),
		.flush     (all_flush),
		.limit     (cfg_q[CFG_TXD_LSB +: CFG_FW]),
		.push      (txd_push),
		.push_data (txd_push_data),
		.pop       (txd_pop),
		.head      (txd_head),
		.count     (txd_cnt),
		.full      (txd_full),
		.empty     (txd_empty)
	);
	// tx status capacity is fixed by its depth
	hfp_fifo #(.W(DW), .DEPTH(TXS_DEPTH)) u_txs (
		.clock     (clock),
		.rst_n     (rst_n),
		.flush     (all_flush),
		.limit     (8'h00),
		.push      (txs_push),
		.push_data (txs_push_data),
		.pop       (txs_pop),
		.head      (txs_head),
		.count     (txs_cnt),
		.full      (),
		.empty     (txs_empty)
	);

	// low half of a 16-bit tx write
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tx_lo_q <= 16'h0000;
		end else if (wr && sel_txd && host_bus16 && !upper_half) begin
			tx_lo_q <= host_req.wdata[15:0];
		end
	end

	// ==========================================================
	// tx drain stage, so the mac side sees flops only
	logic          txd_valid_q;
	logic [DW-1:0] txd_data_q;

	assign txd_pop = ~txd_empty & (~txd_valid_q | txd_take);

	// refill the stage whenever it empties or is taken
	always_ff @(posedge clock) begin
		if (!rst_n || all_flush) begin
			txd_valid_q <= 1'b0;
			txd_data_q  <= '0;
		end else if (txd_pop) begin
			txd_valid_q <= 1'b1;
			txd_data_q  <= txd_head;
		end else if (txd_take) begin
			txd_valid_q <= 1'b0;
		end
	end
	assign txd_valid = txd_valid_q;
	assign txd_data  = txd_data_q;

	// ==========================================================
	// sticky event bits
	logic [EV_NUM-1:0] ev_cond;        // raw event conditions
	logic [EV_NUM-1:0] ev_q;           // visible event bits

	assign ev_cond[EV_RX_OVR]   = rxd_push & rxd_full;
	assign ev_cond[EV_TX_OVR]   = txd_push & txd_full;
	assign ev_cond[EV_RX_UDR]   = (rxd_pop & rxd_empty) |
	                              (rxs_pop & rxs_empty);
	assign ev_cond[EV_LINK_LL]  = link_ok;
	assign ev_cond[EV_ALERT_LH] = alert_in;

	// one attribute cell per event bit
	for (genvar i = 0; i < EV_NUM; i++) begin : g_ev
		hfp_attr_bit #(.KIND(EV_ATTR[i])) u_bit (
			.clock    (clock),
			.rst_n    (rst_n),
			.soft_rst (soft_rst),
			.cond     (ev_cond[i]),
			.rd_clr   (rd & sel_event),
			.wr_one   (wr & sel_event & host_req.wdata[i]),
			.q        (ev_q[i])
		);
	end

	// ==========================================================
	// read data selection
	logic [DW-1:0] rxd_word;           // rx data as the bus width sees it
	logic [DW-1:0] rd_word;
	logic [DW-1:0] host_rdata_q;
	logic          host_rvalid_q;

	assign rxd_word = !host_bus16 ? rxd_head :
	                  upper_half ? {16'h0000, rxd_head[31:16]} :
	                  {16'h0000, rxd_head[15:0]};
	// tx aliases and reserved space read as zero
	assign rd_word =
		sel_rxd ? rxd_word :
		(sel_rxs_pop || sel_rxs_peek) ? rxs_head :
		(sel_txs_pop || sel_txs_peek) ? txs_head :
		sel_ident ? IDENT_VALUE :
		sel_cfg ? cfg_q :
		sel_event ? {{(DW-EV_NUM){1'b0}}, ev_q} :
		sel_action ? {{(DW-ACT_NUM){1'b0}}, act_q} :
		'0;

	// answer one cycle after the read strobe
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			host_rdata_q  <= '0;
			host_rvalid_q <= 1'b0;
		end else begin
			host_rdata_q  <= rd ? rd_word : host_rdata_q;
			host_rvalid_q <= rd;
		end
	end
	assign host_rdata  = host_rdata_q;
	assign host_rvalid = host_rvalid_q;

	// ==========================================================
	// checks
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_rxs_take;
		rd && sel_rxs_pop && !rxs_empty && !rxs_push && !rx_flush;
	endsequence
	sequence s_txs_take;
		rd && sel_txs_pop && !txs_empty && !txs_push && !all_flush;
	endsequence

	AST_RO_IGNORED: assert property (
		wr && !rd && sel_rxd && !rxd_push && !rx_flush
		|=> rxd_cnt == $past(rxd_cnt))
		else $error("write to read-only rx data changed the queue");
	AST_WO_ZERO: assert property (
		rd && sel_txd |=> host_rvalid_q && host_rdata_q == '0)
		else $error("write-only tx data read as nonzero");
	AST_SOFT_KEEP: assert property (
		soft_rst |=> (cfg_q & CFG_KEEP_MASK) ==
		             ($past(cfg_q) & CFG_KEEP_MASK) &&
		             (cfg_q & ~CFG_KEEP_MASK) == '0)
		else $error("soft reset mishandled the config register");
	AST_RESET_DEFAULT: assert property (
		$rose(rst_n) |-> cfg_q == FIFO_CFG_RST && act_q == '0)
		else $error("config not at default after reset");
	AST_RXS_POP: assert property (
		s_rxs_take |=> rxs_cnt == $past(rxs_cnt) - 8'h01 &&
		               host_rdata_q == $past(rxs_head))
		else $error("rx status pop did not return and remove");
	AST_RXS_PEEK: assert property (
		rd && sel_rxs_peek && !rxs_push && !rx_flush
		|=> rxs_cnt == $past(rxs_cnt) && host_rdata_q == $past(rxs_head))
		else $error("rx status peek disturbed the queue");
	AST_RXD_ALIAS: assert property (
		rd && sel_rxd && !host_bus16 && !rxd_empty && !rxd_push && !rx_flush
		|=> host_rdata_q == $past(rxd_head) &&
		    rxd_cnt == $past(rxd_cnt) - 8'h01)
		else $error("rx data alias did not pop the head");
	AST_TXD_ALIAS: assert property (
		wr && sel_txd && !host_bus16 && !txd_full && !txd_pop && !all_flush
		|=> txd_cnt == $past(txd_cnt) + 8'h01)
		else $error("tx data alias did not push");
	AST_TXS_POP: assert property (
		s_txs_take |=> txs_cnt == $past(txs_cnt) - 8'h01)
		else $error("tx status pop did not remove the entry");
	AST_TXS_PEEK: assert property (
		rd && sel_txs_peek && !txs_push && !all_flush
		|=> txs_cnt == $past(txs_cnt) && host_rdata_q == $past(txs_head))
		else $error("tx status peek disturbed the queue");
	AST_SELF_CLEAR: assert property (
		act_q[ACT_SOFT_RST] && !(wr && sel_action)
		|=> act_q == '0 && txd_cnt == 8'h00 && rxd_cnt == 8'h00 &&
		    !txd_valid_q)
		else $error("action bit did not clear itself");

endmodule // hfp_host_port

// >>> tb/hfp_host_model.sv
// host processor model driving the fifo port register window
`timescale 1ns/1ps
module hfp_host_model
	import hfp_pkg::*;
(
	input  wire logic          clock,
	input  wire logic [DW-1:0] host_rdata,
	input  wire logic          host_rvalid,
	output hfp_host_req_s      host_req
);
	// ==========================================================
	// bus cycles: strobe from one falling edge to the next
	initial host_req = '0;

	// only mapped places written, reserved bits sent as zero
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clock);
		host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge clock);
		// released lines never show the last value
		host_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// answer stands one cycle, sampled before release
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
			output logic v);
		@(negedge clock);
		host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: '0};
		@(negedge clock);
		v = host_rvalid;
		d = host_rdata;
		host_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: '1};
	endtask
endmodule // hfp_host_model

// >>> tb/test_hfp_host_port.sv
// self-checking bench of the host fifo port window
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin \
	mismatches++; $display("CHECK FAILED %s exp %h got %h", n, e, s); \
	end end
module test_hfp_host_port
	import hfp_pkg::*;
;
	// ==========================================================
	// signals
	logic          clock, rst_n, host_bus16, txd_take, link_ok, alert_in;
	logic          rxd_push, rxs_push, txs_push, host_rvalid, txd_valid;
	logic [DW-1:0] rxd_push_data, rxs_push_data, txs_push_data;
	logic [DW-1:0] host_rdata, txd_data;
	hfp_host_req_s host_req;  // driven by the host model
	logic [31:0]   d;         // last read answer
	logic          v;         // last read valid
	int            mismatches, n_tests;
	// ordinary cases: write, offset, write data or expected read
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} hfp_row_s;
	hfp_row_s rows [7] = '{'{1'b0, OFS_IDENT, IDENT_VALUE},
		'{1'b1, OFS_IDENT, 32'hffff_ffff}, '{1'b0, OFS_IDENT, IDENT_VALUE},
		'{1'b1, 8'h24, 32'h0000_0011}, '{1'b0, 8'h24, 32'h0000_0000},
		'{1'b1, OFS_FIFO_CFG, 32'hab00_0000},
		'{1'b0, OFS_FIFO_CFG, 32'hab00_0000}};

	hfp_host_port hfp_host_port_i (.clock, .rst_n, .host_req, .host_bus16,
		.host_rdata, .host_rvalid, .rxd_push, .rxd_push_data, .rxs_push,
		.rxs_push_data, .txs_push, .txs_push_data, .txd_take, .txd_valid,
		.txd_data, .link_ok, .alert_in);
	hfp_host_model hfp_host_model_i (.clock, .host_rdata, .host_rvalid,
		.host_req);

	// ==========================================================
	// helpers
	task automatic finish_test;
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// read and compare the masked answer
	task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
		hfp_host_model_i.rd(a, d, v);
		`CHK("rvalid", 1'b1, v)
		`CHK("rdata", e, d & m)
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		hfp_host_model_i.wr(a, x);
	endtask
	// one-cycle mac push: bit0 rx data, bit1 rx status, bit2 tx status
	task automatic push(input logic [2:0] k, input logic [31:0] x);
		@(negedge clock);
		{txs_push, rxs_push, rxd_push} = k;
		{rxd_push_data, rxs_push_data, txs_push_data} = {x, x, ~x};
		@(negedge clock);
		{txs_push, rxs_push, rxd_push} = 3'h0;
	endtask
	// take the staged tx word, then let it refill
	task automatic take;
		txd_take = 1'b1;
		@(negedge clock);
		txd_take = 1'b0;
		@(negedge clock);
	endtask

	// ==========================================================
	// clock and watchdog
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		finish_test;
	end

	// ==========================================================
	// main sequence, inputs move on falling edges
	initial begin
		{rst_n, host_bus16, txd_take, alert_in} = 4'h0;
		{rxd_push, rxs_push, txs_push, link_ok} = 4'h1;
		{rxd_push_data, rxs_push_data, txs_push_data} = '0;
		mismatches = 0;
		n_tests = 0;
		// count rising edges: the first clock step at time zero is a fall
		repeat (4) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		`CHK("rvalid", 1'b0, host_rvalid)
		`CHK("txd_valid", 1'b0, txd_valid)
		rc(OFS_EVENT, 32'h1f, 32'h08);
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			else rc(rows[i].a, '1, rows[i].d);
		end
		`CHK("txd_data", 32'h11, txd_data)
		take;
		`CHK("txd_valid", 1'b0, txd_valid)
		// every tx alias pushes into the one queue
		for (int i = 0; i < 8; i++) wr(OFS_TXD_BASE + 8'(4 * i), 32'(i));
		repeat (2) @(negedge clock);
		for (int i = 0; i < 8; i++) begin
			`CHK("txd_data", 32'(i), txd_data)
			take;
		end
		// every rx alias pops the next word
		for (int i = 0; i < 8; i++) push(3'h1, 32'h100 + 32'(i));
		for (int i = 0; i < 8; i++)
			rc(OFS_RXD_BASE + 8'(4 * i), '1, 32'h100 + 32'(i));
		// peek twice, then pop both, on rx and tx status
		push(3'h6, 32'ha1);
		push(3'h6, 32'hb2);
		for (int k = 0; k < 2; k++) begin
			logic [7:0]  pk;  // peek offset of this queue
			logic [7:0]  pp;  // pop offset of this queue
			logic [31:0] iv;  // tx status carries inverted data
			pk = k ? OFS_TXS_PEEK : OFS_RXS_PEEK;
			pp = k ? OFS_TXS_POP : OFS_RXS_POP;
			iv = k ? 32'hffff_ffff : 32'h0000_0000;
			rc(pk, '1, iv ^ 32'ha1);
			rc(pk, '1, iv ^ 32'ha1);
			rc(pp, '1, iv ^ 32'ha1);
			rc(pp, '1, iv ^ 32'hb2);
		end
		// pop of empty queue leaves the pointer, flags underrun
		hfp_host_model_i.rd(OFS_RXS_POP, d, v);
		push(3'h2, 32'hc3);
		rc(OFS_RXS_POP, '1, 32'hc3);
		rc(OFS_EVENT, 32'h4, 32'h4);
		rc(OFS_EVENT, 32'h4, 32'h0);
		// one-cycle link drop and alert are held until read
		@(negedge clock);
		{link_ok, alert_in} = 2'b01;
		@(negedge clock);
		{link_ok, alert_in} = 2'b10;
		rc(OFS_EVENT, 32'h18, 32'h10);
		rc(OFS_EVENT, 32'h18, 32'h08);
		// overfill tx data, zero write keeps the flag, one clears
		for (int i = 0; i < 20; i++) wr(OFS_TXD_BASE, 32'(i));
		`CHK("txd_data", 32'h0, txd_data)
		rc(OFS_EVENT, 32'h2, 32'h2);
		wr(OFS_EVENT, 32'h0);
		rc(OFS_EVENT, 32'h2, 32'h2);
		wr(OFS_EVENT, 32'h2);
		rc(OFS_EVENT, 32'h2, 32'h0);
		// stage plus queue hold words 0..16, the dropped ones left no mark
		for (int i = 0; i < 17; i++) begin
			`CHK("txd_data", 32'(i), txd_data)
			if (i < 16) take;
		end
		// soft reset keeps the scratch byte, flushes the queues
		wr(OFS_FIFO_CFG, 32'hab00_0012);
		wr(OFS_ACTION, 32'h1);
		rc(OFS_ACTION, 32'h3, 32'h0);
		rc(OFS_FIFO_CFG, '1, 32'hab00_0000);
		`CHK("txd_valid", 1'b0, txd_valid)
		// 16-bit bus: halves pair up, the upper half moves the word
		host_bus16 = 1'b1;
		wr(OFS_TXD_BASE, 32'h0000_5678);
		wr(OFS_TXD_BASE + 8'h02, 32'h0000_1234);
		repeat (2) @(negedge clock);
		`CHK("txd_data", 32'h1234_5678, txd_data)
		push(3'h1, 32'hdead_beef);
		push(3'h1, 32'hcafe_f00d);
		rc(OFS_RXD_BASE, '1, 32'h0000_beef);
		rc(OFS_RXD_BASE + 8'h02, '1, 32'h0000_dead);
		rc(OFS_RXD_BASE + 8'h1c, '1, 32'h0000_f00d);
		rc(OFS_RXD_BASE + 8'h1e, '1, 32'h0000_cafe);
		host_bus16 = 1'b0;
		// rx data limited to two words; a write to it pushes nothing
		wr(OFS_FIFO_CFG, 32'h0000_0002);
		wr(OFS_RXD_BASE + 8'h08, 32'h0000_0099);
		for (int i = 0; i < 3; i++) push(3'h1, 32'h21 + 32'(i));
		rc(OFS_RXD_BASE, '1, 32'h21);
		rc(OFS_RXD_BASE, '1, 32'h22);
		hfp_host_model_i.rd(OFS_RXD_BASE, d, v);
		rc(OFS_EVENT, 32'h5, 32'h5);
		// rx flush action empties the rx data queue
		push(3'h1, 32'h31);
		wr(OFS_ACTION, 32'h2);
		hfp_host_model_i.rd(OFS_RXD_BASE, d, v);
		rc(OFS_EVENT, 32'h4, 32'h4);
		finish_test;
	end
endmodule // test_hfp_host_port
